// ===== rtl/fbc_pkg.sv
// Constants, register map and field layout for the four-bit synchronous counter.
package fbc_pkg;

	// Counter geometry.
	localparam int unsigned COUNT_W = 4;
	localparam logic [COUNT_W-1:0] COUNT_ZERO = 4'h0;
	localparam logic [COUNT_W-1:0] COUNT_ONE = 4'h1;
	localparam logic [COUNT_W-1:0] COUNT_TERMINAL = 4'hf;

	// Wrap tally width and step.
	localparam int unsigned WRAP_W = 16;
	localparam logic [WRAP_W-1:0] WRAP_ZERO = 16'h0000;
	localparam logic [WRAP_W-1:0] WRAP_ONE = 16'h0001;

	// APB geometry.
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

	// Register byte offsets.
	localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_PRESET = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_WRAPS = 12'h00c;

	// STATUS fields.
	localparam int unsigned ST_COUNT_LSB = 0;
	localparam int unsigned ST_CARRY_BIT = 4;
	localparam int unsigned ST_PEN_BIT = 5;
	localparam int unsigned ST_TEN_BIT = 6;
	localparam int unsigned ST_LOADN_BIT = 7;

	// CTRL fields.
	localparam int unsigned CT_GATE_BIT = 0;
	localparam int unsigned CT_LOAD_BIT = 1;
	localparam int unsigned CT_TALLY_CLR_BIT = 2;
	localparam logic CT_GATE_RESET = 1'b1;

	// PRESET reset value.
	localparam logic [COUNT_W-1:0] PRESET_RESET = 4'h0;

	// Operation selected at a clock edge.
	typedef enum logic [1:0] {
		FBC_OP_HOLD,
		FBC_OP_LOAD,
		FBC_OP_COUNT
	} fbc_op_t;

	// APB slave phases.
	typedef enum logic [1:0] {
		FBC_BUS_IDLE,
		FBC_BUS_WAIT,
		FBC_BUS_DONE
	} fbc_bus_t;

endpackage : fbc_pkg

// ===== rtl/fbc_count_core.sv
// Four-bit presettable count register with asynchronous clear.
`timescale 1ns/10ps
module fbc_count_core
(
	// Clock and resets.
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic async_zero_reset_n_i,
	// Operation for this edge.
	input wire fbc_pkg::fbc_op_t op_i,
	input wire logic [fbc_pkg::COUNT_W-1:0] load_value_i,
	// State.
	output logic [fbc_pkg::COUNT_W-1:0] count_o,
	output logic wrap_o
);

	logic [fbc_pkg::COUNT_W-1:0] next_count;
	logic next_wrap;

	// Next-state decode; the adder is a full-width sum, so every bit settles together.
	always_comb
	begin
		next_count = count_o;
		next_wrap = 1'b0;
		case (op_i)
			fbc_pkg::FBC_OP_LOAD: next_count = load_value_i;
			fbc_pkg::FBC_OP_COUNT:
			begin
				next_count = count_o + fbc_pkg::COUNT_ONE;
				next_wrap = (count_o == fbc_pkg::COUNT_TERMINAL);
			end
			fbc_pkg::FBC_OP_HOLD: next_count = count_o;
			default: next_count = count_o;
		endcase
	end

	// One register for all four bits on one clock; clear acts without the clock.
	always_ff @(posedge clk_i or negedge async_zero_reset_n_i)
	begin
		if (!async_zero_reset_n_i)
		begin
			count_o <= fbc_pkg::COUNT_ZERO;
			wrap_o <= 1'b0;
		end
		else if (!nrst_i)
		begin
			count_o <= fbc_pkg::COUNT_ZERO;
			wrap_o <= 1'b0;
		end
		else
		begin
			count_o <= next_count;
			wrap_o <= next_wrap;
		end
	end

endmodule : fbc_count_core

// ===== rtl/fbc_wrap_tally.sv
// Saturating tally of counter wraps from fifteen to zero.
`timescale 1ns/10ps
module fbc_wrap_tally
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic nrst_i,
	// Events.
	input wire logic wrap_i,
	input wire logic clear_i,
	// Tally.
	output logic [fbc_pkg::WRAP_W-1:0] tally_o
);

	// Saturate rather than roll over so software never misreads a huge run as a few.
	// A wrap in the clearing cycle wins and is counted as the first of the new run.
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
			tally_o <= fbc_pkg::WRAP_ZERO;
		else if (clear_i && wrap_i)
			tally_o <= fbc_pkg::WRAP_ONE;
		else if (clear_i)
			tally_o <= fbc_pkg::WRAP_ZERO;
		else if (wrap_i && (tally_o != '1))
			tally_o <= tally_o + fbc_pkg::WRAP_ONE;
	end

endmodule : fbc_wrap_tally

// ===== rtl/fbc_counter_top.sv
// Top of the four-bit synchronous counter with its APB register slave.
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
module fbc_counter_top
(
	// Clock and bus reset.
	input wire logic clk_i,
	input wire logic nrst_i,
	// Counter control pins.
	input wire logic async_zero_reset_n_i,
	input wire logic load_n_i,
	input wire logic parallel_count_enable_i,
	input wire logic trickle_count_enable_i,
	input wire logic [3:0] data_i,
	// Counter outputs.
	output logic count_out_bit0_o,
	output logic count_out_bit1_o,
	output logic count_out_bit2_o,
	output logic count_out_bit3_o,
	output logic ripple_carry_out_o,
	// APB slave.
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [fbc_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [fbc_pkg::DATA_W-1:0] pwdata_i,
	output logic [fbc_pkg::DATA_W-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o
);

	// Address decode shared by the read and write paths.
	function automatic logic fbc_is_mapped(input logic [fbc_pkg::ADDR_W-1:0] addr);
		fbc_is_mapped = (addr == fbc_pkg::OFS_STATUS) || (addr == fbc_pkg::OFS_CTRL) ||
			(addr == fbc_pkg::OFS_PRESET) || (addr == fbc_pkg::OFS_WRAPS);
	endfunction : fbc_is_mapped

	// The writable registers, CTRL and PRESET, refuse nothing; STATUS and WRAPS are read only.
	function automatic logic fbc_is_writable(input logic [fbc_pkg::ADDR_W-1:0] addr);
		fbc_is_writable = (addr == fbc_pkg::OFS_CTRL) || (addr == fbc_pkg::OFS_PRESET);
	endfunction : fbc_is_writable

	// Software state.
	logic count_gate;
	logic sw_load;
	logic [fbc_pkg::COUNT_W-1:0] preset_value;
	logic tally_clear;

	// Counter state.
	logic [fbc_pkg::COUNT_W-1:0] count;
	logic wrap;
	logic [fbc_pkg::WRAP_W-1:0] tally;
	fbc_pkg::fbc_op_t op;
	logic [fbc_pkg::COUNT_W-1:0] load_value;

	// Bus state.
	fbc_pkg::fbc_bus_t bus_state;
	logic bus_write;
	logic bus_take;

	// Operation select: load first, then count, else hold.
	// Only the level present at the sampling edge matters, so enables may
	// toggle freely between edges without any effect on the count.
	always_comb
	begin
		op = fbc_pkg::FBC_OP_HOLD;
		load_value = data_i;
		if (!load_n_i)
		begin
			op = fbc_pkg::FBC_OP_LOAD;
			load_value = data_i;
		end
		else if (sw_load)
		begin
			op = fbc_pkg::FBC_OP_LOAD;
			load_value = preset_value;
		end
		else if (parallel_count_enable_i && trickle_count_enable_i && count_gate)
			op = fbc_pkg::FBC_OP_COUNT;
	end

	// Count register.
	fbc_count_core u_core
	(
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.async_zero_reset_n_i(async_zero_reset_n_i),
		.op_i(op),
		.load_value_i(load_value),
		.count_o(count),
		.wrap_o(wrap)
	);

	// Wrap tally read through WRAPS.
	fbc_wrap_tally u_tally
	(
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.wrap_i(wrap),
		.clear_i(tally_clear),
		.tally_o(tally)
	);

	// Count bits leave straight from the count register, one bit to a pin.
	assign count_out_bit0_o = count[0];
	assign count_out_bit1_o = count[1];
	assign count_out_bit2_o = count[2];
	assign count_out_bit3_o = count[3];

	// The carry must follow the trickle enable without waiting for a clock, so
	// cascaded stages see it in the same cycle; that makes it a gate, not a flop,
	// and a glitch is possible while the count settles.
	assign ripple_carry_out_o = (count == fbc_pkg::COUNT_TERMINAL) && trickle_count_enable_i;

	// A request is taken in the first access cycle; the answer follows one cycle later.
	assign bus_take = psel_i && penable_i && (bus_state == fbc_pkg::FBC_BUS_IDLE);
	assign bus_write = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;

	// Bus phase tracker.
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
			bus_state <= fbc_pkg::FBC_BUS_IDLE;
		else
		begin
			case (bus_state)
				fbc_pkg::FBC_BUS_IDLE:
					if (bus_take)
						bus_state <= fbc_pkg::FBC_BUS_WAIT;
				fbc_pkg::FBC_BUS_WAIT: bus_state <= fbc_pkg::FBC_BUS_DONE;
				fbc_pkg::FBC_BUS_DONE: bus_state <= fbc_pkg::FBC_BUS_IDLE;
				default: bus_state <= fbc_pkg::FBC_BUS_IDLE;
			endcase
		end
	end

	// Ready and error: high for exactly one cycle, the second access cycle.
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end
		else
		begin
			pready_o <= bus_take;
			pslverr_o <= bus_take && (!fbc_is_mapped(paddr_i) ||
				(pwrite_i && !fbc_is_writable(paddr_i)));
		end
	end

	// Read data is snapshotted when the request is taken, so the word stays still
	// for the whole answer cycle even though the count may move meanwhile.
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
			prdata_o <= fbc_pkg::DATA_ZERO;
		else if (bus_take && !pwrite_i)
		begin
			prdata_o <= fbc_pkg::DATA_ZERO;
			case (paddr_i)
				fbc_pkg::OFS_STATUS:
				begin
					prdata_o[fbc_pkg::ST_COUNT_LSB +: fbc_pkg::COUNT_W] <= count;
					prdata_o[fbc_pkg::ST_CARRY_BIT] <= ripple_carry_out_o;
					prdata_o[fbc_pkg::ST_PEN_BIT] <= parallel_count_enable_i;
					prdata_o[fbc_pkg::ST_TEN_BIT] <= trickle_count_enable_i;
					prdata_o[fbc_pkg::ST_LOADN_BIT] <= load_n_i;
				end
				fbc_pkg::OFS_CTRL:
					prdata_o[fbc_pkg::CT_GATE_BIT] <= count_gate;
				fbc_pkg::OFS_PRESET:
					prdata_o[fbc_pkg::COUNT_W-1:0] <= preset_value;
				fbc_pkg::OFS_WRAPS:
					prdata_o[fbc_pkg::WRAP_W-1:0] <= tally;
				default: prdata_o <= fbc_pkg::DATA_ZERO;
			endcase
		end
		else if (bus_take)
			prdata_o <= fbc_pkg::DATA_ZERO;
	end

	// Count gate: software may freeze counting without touching the enable pins.
	// It gates only the parallel path, so the carry to later stages is unaffected.
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
			count_gate <= fbc_pkg::CT_GATE_RESET;
		else if (bus_write && (paddr_i == fbc_pkg::OFS_CTRL))
			count_gate <= pwdata_i[fbc_pkg::CT_GATE_BIT];
	end

	// Software load and tally clear are one-cycle strobes from CTRL writes.
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			sw_load <= 1'b0;
			tally_clear <= 1'b0;
		end
		else
		begin
			sw_load <= bus_write && (paddr_i == fbc_pkg::OFS_CTRL) &&
				pwdata_i[fbc_pkg::CT_LOAD_BIT];
			tally_clear <= bus_write && (paddr_i == fbc_pkg::OFS_CTRL) &&
				pwdata_i[fbc_pkg::CT_TALLY_CLR_BIT];
		end
	end

	// Preset value used by a software load; any of the sixteen values is allowed.
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
			preset_value <= fbc_pkg::PRESET_RESET;
		else if (bus_write && (paddr_i == fbc_pkg::OFS_PRESET))
			preset_value <= pwdata_i[fbc_pkg::COUNT_W-1:0];
	end

endmodule : fbc_counter_top

// ===== test/fbc_counter_monitor.sv
// Assertion checker for the counter pins and the bus handshake.
`timescale 1ns/10ps
module fbc_counter_monitor
(
	// Clock and resets.
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic async_zero_reset_n_i,
	// Counter pins.
	input wire logic load_n_i,
	input wire logic parallel_count_enable_i,
	input wire logic trickle_count_enable_i,
	input wire logic [3:0] data_i,
	input wire logic count_out_bit0_o,
	input wire logic count_out_bit1_o,
	input wire logic count_out_bit2_o,
	input wire logic count_out_bit3_o,
	input wire logic ripple_carry_out_o,
	// Bus handshake.
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [fbc_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [fbc_pkg::DATA_W-1:0] pwdata_i,
	input wire logic pready_o,
	input wire logic pslverr_o
);
	logic [3:0] cnt;
	logic run;
	logic ctrl_write;
	logic sw_gate;
	logic sw_strobe;

	// Gather the count and the counting condition seen at an edge.
	assign cnt = {count_out_bit3_o, count_out_bit2_o, count_out_bit1_o, count_out_bit0_o};
	assign run = load_n_i && parallel_count_enable_i && trickle_count_enable_i && sw_gate &&
		!sw_strobe;
	// A control write lands at the edge that sees ready without an error.
	assign ctrl_write = psel_i && penable_i && pwrite_i && pready_o && !pslverr_o &&
		(paddr_i == fbc_pkg::OFS_CTRL);

	// Software may gate counting or load the preset; the pin checks must skip those edges.
	always_ff @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			sw_gate <= fbc_pkg::CT_GATE_RESET;
			sw_strobe <= 1'b0;
		end
		else
		begin
			sw_strobe <= ctrl_write && pwdata_i[fbc_pkg::CT_LOAD_BIT];
			if (ctrl_write)
				sw_gate <= pwdata_i[fbc_pkg::CT_GATE_BIT];
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i || !async_zero_reset_n_i);

	// Counting at the top value, and two counting edges in a row.
	sequence s_top;
		run && cnt == 4'hf;
	endsequence
	sequence s_run2;
		run [*2];
	endsequence

	AST_LOAD: assert property (!load_n_i |=> cnt == $past(data_i))
		else $error("parallel load value not taken");
	AST_COUNT: assert property (run |=> cnt == $past(cnt) + 4'h1)
		else $error("enabled edge did not add one");
	AST_HOLD: assert property (load_n_i && !sw_strobe && !run |=> $stable(cnt))
		else $error("count moved while inhibited");
	AST_WRAP: assert property (s_top |=> cnt == 4'h0)
		else $error("top value did not wrap to zero");
	AST_SYNC: assert property (s_run2 |=> cnt == $past(cnt, 2) + 4'h2)
		else $error("two counting edges did not add two");
	AST_CLR: assert property (disable iff (!nrst_i) !async_zero_reset_n_i |-> cnt == 4'h0)
		else $error("count not zero under clear");
	AST_CARRY: assert property (ripple_carry_out_o == (cnt == 4'hf && trickle_count_enable_i))
		else $error("carry does not match count and trickle enable");
	AST_ACK: assert property (psel_i && $rose(penable_i) |=> pready_o)
		else $error("no ready one cycle after access");
	AST_PULSE: assert property (pready_o |=> !pready_o)
		else $error("ready longer than one cycle");
	AST_ERR: assert property (pslverr_o |-> pready_o)
		else $error("error without ready");
endmodule : fbc_counter_monitor

bind fbc_counter_top fbc_counter_monitor mon_u
(
	.clk_i, .nrst_i, .async_zero_reset_n_i, .load_n_i, .parallel_count_enable_i,
	.trickle_count_enable_i, .data_i, .count_out_bit0_o, .count_out_bit1_o,
	.count_out_bit2_o, .count_out_bit3_o, .ripple_carry_out_o, .psel_i, .penable_i,
	.pwrite_i, .paddr_i, .pwdata_i, .pready_o, .pslverr_o
);

// ===== test/fbc_pin_model.sv
// Model of the control logic that drives the counter pins.
`timescale 1ns/10ps
module fbc_pin_model
(
	// Clock.
	input wire logic clk_i,
	// Pins towards the counter.
	output logic clr_n_o,
	output logic load_n_o,
	output logic pen_o,
	output logic ten_o,
	output logic [3:0] data_o
);
	// Start with the clear held and everything else idle.
	initial
	begin
		clr_n_o = 1'b0;
		load_n_o = 1'b1;
		pen_o = 1'b0;
		ten_o = 1'b0;
		data_o = 4'h0;
	end

	// Pins change just after an edge; data outside a load is junk, as the counter ignores it.
	task automatic drive(input logic c, input logic l, input logic p, input logic t,
		input logic [3:0] d);
		@(posedge clk_i);
		clr_n_o <= c;
		load_n_o <= l;
		pen_o <= p;
		ten_o <= t;
		data_o <= l ? ~d : d;
	endtask : drive
endmodule : fbc_pin_model

// ===== test/fbc_counter_top_tb.sv
// Self-checking bench for the four-bit counter and its bus slave.
`timescale 1ns/10ps
module fbc_counter_top_tb;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [fbc_pkg::ADDR_W-1:0] paddr_i = 12'h000;
	logic [fbc_pkg::DATA_W-1:0] pwdata_i = 32'h0;
	logic [fbc_pkg::DATA_W-1:0] prdata_o;
	logic [fbc_pkg::DATA_W-1:0] rd;
	logic [3:0] din;
	logic [3:0] cnt;
	logic pready_o, pslverr_o, err, clr_n, load_n, pen, ten, carry, q0, q1, q2, q3;
	int miscompares = 0;
	int cmp_count = 0;

	// Bit zero of the count is the least significant pin.
	assign cnt = {q3, q2, q1, q0};

	// A 10 MHz clock.
	always #50 clk_i = ~clk_i;

	fbc_pin_model drv_u
	(
		.clk_i(clk_i), .clr_n_o(clr_n), .load_n_o(load_n), .pen_o(pen), .ten_o(ten),
		.data_o(din)
	);

	fbc_counter_top dut_u
	(
		.clk_i(clk_i), .nrst_i(nrst_i), .async_zero_reset_n_i(clr_n), .load_n_i(load_n),
		.parallel_count_enable_i(pen), .trickle_count_enable_i(ten), .data_i(din),
		.count_out_bit0_o(q0), .count_out_bit1_o(q1), .count_out_bit2_o(q2),
		.count_out_bit3_o(q3), .ripple_carry_out_o(carry), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o)
	);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : test_done

	// Pins {clear, load, enables} change at an edge; judge what that edge left.
	task automatic go(input logic [3:0] pins, input logic [3:0] d, input logic [3:0] exp);
		drv_u.drive(pins[3], pins[2], pins[1], pins[0], d);
		#1;
		chk(cnt, exp);
		chk(carry, exp == 4'hf && pins[0]);
	endtask : go

	// One transfer; the request stands until ready is seen, and the answer is kept.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (pready_o !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			miscompares++;
			test_done();
		end
		else
		begin
			rd = prdata_o;
			err = pslverr_o;
			psel_i <= 1'b0;
			penable_i <= 1'b0;
		end
	endtask : apb

	// Clear, preset twelve, count through the wrap, inhibit, then clear under load.
	task automatic t_seq;
		go(4'h0, 4'h0, 4'h0);
		go(4'h8, 4'hc, 4'h0);
		go(4'hf, 4'h0, 4'hc);
		go(4'hf, 4'h0, 4'hd);
		go(4'hf, 4'h0, 4'he);
		go(4'hf, 4'h0, 4'hf);
		go(4'hd, 4'h0, 4'h0);
		go(4'hd, 4'h0, 4'h0);
		go(4'h8, 4'hf, 4'h0);
		go(4'he, 4'h0, 4'hf);
		go(4'hd, 4'h0, 4'hf);
		go(4'h3, 4'h9, 4'h0);
		go(4'h3, 4'h9, 4'h0);
		go(4'hd, 4'h0, 4'h0);
	endtask : t_seq

	// Load downwards with both enables high, so a count instead of a load would show.
	task automatic t_load;
		go(4'hb, 4'hf, 4'h0);
		for (int v = 14; v >= 0; v--)
			go(4'hb, 4'(v), 4'(v + 1));
		go(4'hd, 4'h0, 4'h0);
	endtask : t_load

	// Status, reset values, preset, wrap tally, refused accesses, gate and software load.
	task automatic t_regs;
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0000_00c0);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h0000_0001);
		apb(1'b1, 12'h008, 32'h0000_0005);
		apb(1'b0, 12'h008, 32'h0);
		chk({rd[30:0], err}, 32'h0000_000a);
		apb(1'b0, 12'h00c, 32'h0);
		chk(rd, 32'h0000_0001);
		apb(1'b1, 12'h004, 32'h0000_0005);
		apb(1'b0, 12'h00c, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, 12'h000, 32'h0000_00ff);
		chk(err, 1'b1);
		apb(1'b0, 12'h010, 32'h0);
		chk(err, 1'b1);
		chk(cnt, 4'h0);
		// Gate closed: the pins ask to count, but the count must stay put.
		apb(1'b1, 12'h004, 32'h0000_0000);
		go(4'hf, 4'h0, 4'h0);
		go(4'hf, 4'h0, 4'h0);
		go(4'hd, 4'h0, 4'h0);
		// Reopen the gate and load the stored preset of five from software.
		apb(1'b1, 12'h004, 32'h0000_0003);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0000_00c5);
		chk(cnt, 4'h5);
	endtask : t_regs

	// Reset for twenty cycles, run every scenario, then report.
	initial
	begin
		repeat (20) @(posedge clk_i);
		nrst_i <= 1'b1;
		t_seq();
		t_load();
		t_regs();
		test_done();
	end
endmodule : fbc_counter_top_tb
